// ===== hw/disp_tx_pkg.sv
// shared constants and types of the display transmitter
package disp_tx_pkg;
  // apb register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  // control fields
  localparam int CTRL_EDGE_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_BAL_BIT = 2;
  localparam int CTRL_MODE_LSB = 3;
  localparam int CTRL_RANGE_BIT = 5;
  localparam int CTRL_WAKE_BIT = 6;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  // status fields
  localparam int STAT_HIGH_BIT = 0;
  localparam int STAT_AWAKE_BIT = 1;
  localparam int STAT_CNT_LSB = 8;
  // pixel and lane geometry
  localparam int COLOR_W = 16;
  localparam int PIX_BITS = 24;
  localparam int LANES = 8;
  localparam int WORD_BITS = 7;
  localparam int LANE_DATA = 6;
  localparam logic [6:0] LINK_CLK_PATTERN = 7'h63;
  localparam logic [5:0] BLANK_HI = 6'h38;
  localparam logic [5:0] BLANK_LO = 6'h07;
  // frequency measurement timing
  localparam int SYS_CLK_MHZ = 125;
  localparam int MEAS_WIN_NS = 4096;
  localparam int MEAS_WIN_CYCLES = MEAS_WIN_NS * SYS_CLK_MHZ / 1000;
  localparam int DIV_LOG = 2;
  localparam int RANGE_SHIFT_MHZ = 60;
  localparam int RANGE_THRESH =
    RANGE_SHIFT_MHZ * MEAS_WIN_NS / ((2 ** DIV_LOG) * 1000);
  localparam int MEAS_CNT_W = 10;
  // pixel width modes
  typedef enum logic [1:0] {
    WIDTH_SINGLE = 2'b00,
    WIDTH_DUAL = 2'b01,
    WIDTH_HALF = 2'b10,
    WIDTH_RSVD = 2'b11
  } width_mode_t;
  // pairing state for single-in dual-out
  typedef enum logic {
    PAIR_FIRST = 1'b0,
    PAIR_SECOND = 1'b1
  } pair_state_t;
endpackage : disp_tx_pkg

// ===== hw/lane_if.sv
// lane word carrier between the transmitter core and a serializer
interface lane_if #(parameter int W = 7) ();
  logic [W-1:0] word;
  logic load;
  logic bit_out;
  modport src (output word, output load, input bit_out);
  modport ser (input word, input load, output bit_out);
endinterface : lane_if

// ===== hw/lane_serializer.sv
// one serial lane: parallel word in, bit stream out lsb first
module lane_serializer #(parameter int W = 7) (
  // link clock and reset
  input wire logic clk,
  input wire logic rst,
  // lane word and serial bit
  lane_if.ser lane
);
  logic [W-1:0] shift_ff;
  logic [W-1:0] nxt_shift;

  // reload on word boundary, otherwise shift down
  assign nxt_shift = lane.load ? lane.word : {1'b0, shift_ff[W-1:1]};

  // shift register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_ff <= '0;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  assign lane.bit_out = shift_ff[0];
endmodule : lane_serializer

// ===== hw/disp_tx.sv
// dual pixel serial display transmitter: capture, coding, lanes, apb
module disp_tx (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [disp_tx_pkg::ADDR_W-1:0] paddr,
  input wire logic [disp_tx_pkg::DATA_W-1:0] pwdata,
  output logic [disp_tx_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // parallel pixel input
  input wire logic pixel_clock_input,
  input wire logic [disp_tx_pkg::COLOR_W-1:0] red_in,
  input wire logic [disp_tx_pkg::COLOR_W-1:0] green_in,
  input wire logic [disp_tx_pkg::COLOR_W-1:0] blue_in,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic data_enable_in,
  // serial lanes
  output logic [disp_tx_pkg::LANES-1:0] serial_lane_pos,
  output logic [disp_tx_pkg::LANES-1:0] serial_lane_neg,
  output logic [disp_tx_pkg::LANES-1:0] serial_lane_oe,
  // link clocks
  output logic primary_link_clock_pos,
  output logic primary_link_clock_neg,
  output logic primary_link_clock_oe,
  output logic secondary_link_clock_pos,
  output logic secondary_link_clock_neg,
  output logic secondary_link_clock_oe
);
  import disp_tx_pkg::*;

  localparam int IN_W = 3 * COLOR_W + 3;

  //////////////////////////////////////////////////////////////////////
  // system domain: apb registers

  logic [CTRL_W-1:0] ctrl_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] status_w;
  logic [DATA_W-1:0] nxt_rdata;
  logic sel_ctrl;
  logic sel_stat;
  logic wr_ctrl;
  logic high_range_ff;
  logic [MEAS_CNT_W-1:0] meas_ff;
  logic awake_meta_ff;
  logic awake_sys_ff;

  // address decode and strobes
  assign sel_ctrl = (paddr == CTRL_OFS);
  assign sel_stat = (paddr == STATUS_OFS);
  assign wr_ctrl = psel & penable & pwrite & sel_ctrl;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(sel_ctrl | sel_stat);
  assign prdata = rdata_ff;

  // status word from own state
  assign status_w = {{(DATA_W - STAT_CNT_LSB - MEAS_CNT_W){1'b0}}, meas_ff,
    {(STAT_CNT_LSB - 2){1'b0}}, awake_sys_ff, high_range_ff};

  // read mux, unmapped reads zero
  assign nxt_rdata = sel_ctrl ? {{(DATA_W - CTRL_W){1'b0}}, ctrl_ff} :
                     sel_stat ? status_w : '0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= pwdata[CTRL_W-1:0];
    end
  end

  // read data latched in setup phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (psel & ~penable & ~pwrite) begin
      rdata_ff <= nxt_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // system domain: pixel clock frequency measurement

  logic tog_meta_ff;
  logic tog_sync_ff;
  logic tog_last_ff;
  logic tog_edge;
  logic win_end;
  logic range_auto;
  logic [MEAS_CNT_W-1:0] win_cnt_ff;
  logic [MEAS_CNT_W-1:0] edge_cnt_ff;
  logic [MEAS_CNT_W-1:0] nxt_edge_cnt;
  logic [DIV_LOG:0] div_ff;

  assign tog_edge = tog_sync_ff ^ tog_last_ff;
  assign win_end = (win_cnt_ff == MEAS_CNT_W'(MEAS_WIN_CYCLES - 1));
  assign nxt_edge_cnt = edge_cnt_ff + MEAS_CNT_W'(tog_edge);
  // range select high enables auto range
  assign range_auto = ctrl_ff[CTRL_RANGE_BIT];

  // synchronise divided pixel clock toggle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tog_meta_ff <= 1'b0;
      tog_sync_ff <= 1'b0;
      tog_last_ff <= 1'b0;
    end else begin
      tog_meta_ff <= div_ff[DIV_LOG];
      tog_sync_ff <= tog_meta_ff;
      tog_last_ff <= tog_sync_ff;
    end
  end

  // window and edge counters
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      win_cnt_ff <= '0;
      edge_cnt_ff <= '0;
    end else begin
      win_cnt_ff <= win_end ? '0 : win_cnt_ff + 1'b1;
      edge_cnt_ff <= win_end ? '0 : nxt_edge_cnt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meas_ff <= '0;
      high_range_ff <= 1'b0;
    end else if (win_end) begin
      meas_ff <= nxt_edge_cnt;
      high_range_ff <= range_auto &
        (nxt_edge_cnt >= MEAS_CNT_W'(RANGE_THRESH));
    end else if (!range_auto) begin
      // manual setting drops the high range at once
      high_range_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // link domain: reset and control synchronisers

  logic link_rst_meta_ff;
  logic link_rst_ff;
  logic [CTRL_W-1:0] ctrl_meta_ff;
  logic [CTRL_W-1:0] ctrl_mid_ff;
  logic [CTRL_W-1:0] ctrl_chk_ff;
  logic [CTRL_W-1:0] ctrl_sync_ff;
  logic [CTRL_W-1:0] nxt_ctrl_sync;

  // only a word seen twice in a row is taken, so skewed bits never mix
  assign nxt_ctrl_sync = (ctrl_mid_ff == ctrl_chk_ff) ? ctrl_mid_ff :
                         ctrl_sync_ff;

  // reset held until two pixel clock edges after release
  always_ff @(posedge pixel_clock_input or posedge rst) begin
    if (rst) begin
      link_rst_meta_ff <= 1'b1;
      link_rst_ff <= 1'b1;
    end else begin
      link_rst_meta_ff <= 1'b0;
      link_rst_ff <= link_rst_meta_ff;
    end
  end

  // quasi-static selects cross by four flops, the last loading only a matched word
  always_ff @(posedge pixel_clock_input or posedge link_rst_ff) begin
    if (link_rst_ff) begin
      ctrl_meta_ff <= CTRL_RESET;
      ctrl_mid_ff <= CTRL_RESET;
      ctrl_chk_ff <= CTRL_RESET;
      ctrl_sync_ff <= CTRL_RESET;
    end else begin
      ctrl_meta_ff <= ctrl_ff;
      ctrl_mid_ff <= ctrl_meta_ff;
      ctrl_chk_ff <= ctrl_mid_ff;
      ctrl_sync_ff <= nxt_ctrl_sync;
    end
  end

  // awake state back to system domain
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awake_meta_ff <= 1'b0;
      awake_sys_ff <= 1'b0;
    end else begin
      awake_meta_ff <= ctrl_sync_ff[CTRL_WAKE_BIT];
      awake_sys_ff <= awake_meta_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // link domain: capture

  logic edge_s;
  logic pol_s;
  logic bal_s;
  logic awake_s;
  width_mode_t mode_s;
  logic single_s;
  logic half_s;
  logic [IN_W-1:0] in_vec;
  logic [IN_W-1:0] cap_rise_ff;
  logic [IN_W-1:0] cap_fall_ff;
  logic [IN_W-1:0] pix_ff;

  assign edge_s = ctrl_sync_ff[CTRL_EDGE_BIT];
  assign pol_s = ctrl_sync_ff[CTRL_POL_BIT];
  assign bal_s = ctrl_sync_ff[CTRL_BAL_BIT];
  assign awake_s = ctrl_sync_ff[CTRL_WAKE_BIT];
  assign mode_s = width_mode_t'(ctrl_sync_ff[CTRL_MODE_LSB+:2]);
  assign single_s = (mode_s == WIDTH_SINGLE) | (mode_s == WIDTH_RSVD);
  assign half_s = (mode_s == WIDTH_HALF);
  assign in_vec = {data_enable_in, vsync_in, hsync_in,
                   red_in, green_in, blue_in};

  always_ff @(posedge pixel_clock_input) begin
    cap_rise_ff <= in_vec;
  end

  always_ff @(negedge pixel_clock_input) begin
    cap_fall_ff <= in_vec;
  end

  always_ff @(posedge pixel_clock_input or posedge link_rst_ff) begin
    if (link_rst_ff) begin
      pix_ff <= '0;
    end else begin
      pix_ff <= edge_s ? cap_rise_ff : cap_fall_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // link domain: word timing, pairing and coding

  logic [2:0] phase_ff;
  logic load_w;
  logic active_w;
  pair_state_t pair_ff;
  pair_state_t nxt_pair;
  logic [PIX_BITS-1:0] first_pix_ff;
  logic first_act_ff;
  logic [PIX_BITS-1:0] pix_lo;
  logic [PIX_BITS-1:0] pix_hi;
  logic [PIX_BITS-1:0] sel_a;
  logic [PIX_BITS-1:0] sel_b;
  logic act_a;
  logic [3:0] ctrl_bits;
  logic upd_words;
  logic pri_clk_ff;
  logic [LANES-1:0][WORD_BITS-1:0] lane_word_ff;
  logic [LANES-1:0][WORD_BITS-1:0] nxt_word;
  logic [LANES-1:0] lane_bit;

  // lane word: flag bit over six data bits
  function automatic logic [WORD_BITS-1:0] encode(
    input logic [LANE_DATA-1:0] d, input logic c,
    input logic act, input logic dc_equalized_coding_select);
    int ones;
    logic inv;
    ones = 0;
    for (int i = 0; i < LANE_DATA; i++) begin
      ones = ones + int'(d[i]);
    end
    inv = (ones > LANE_DATA / 2);
    if (!dc_equalized_coding_select) begin
      encode = {c, act ? d : 6'h00};
    end else if (!act) begin
      encode = {1'b0, c ? BLANK_HI : BLANK_LO};
    end else begin
      encode = {inv, inv ? ~d : d};
    end
  endfunction : encode

  assign load_w = (phase_ff == 3'(WORD_BITS - 1));
  assign active_w = (pix_ff[IN_W-1] == pol_s);
  assign ctrl_bits = {1'b0, pix_ff[IN_W-1:IN_W-3]};
  assign pix_lo = {pix_ff[3*COLOR_W-9-:8], pix_ff[2*COLOR_W-9-:8],
                   pix_ff[COLOR_W-9-:8]};
  assign pix_hi = {pix_ff[3*COLOR_W-1-:8], pix_ff[2*COLOR_W-1-:8],
                   pix_ff[COLOR_W-1-:8]};
  // half mode sends stored first pixel beside current
  assign sel_a = half_s ? first_pix_ff : pix_lo;
  assign act_a = half_s ? first_act_ff : active_w;
  assign sel_b = half_s ? pix_lo : pix_hi;
  assign upd_words = load_w & ~(half_s & (pair_ff == PAIR_FIRST));

  always_comb begin
    nxt_word = lane_word_ff;
    if (upd_words) begin
      for (int k = 0; k < 4; k++) begin
        nxt_word[k] = encode(sel_a[LANE_DATA*k+:LANE_DATA],
                             ctrl_bits[k], act_a, bal_s);
        nxt_word[k+4] = single_s ? '0 :
          encode(sel_b[LANE_DATA*k+:LANE_DATA], ctrl_bits[k],
                 active_w, bal_s);
      end
    end
  end

  always_comb begin
    nxt_pair = pair_ff;
    unique case (pair_ff)
      PAIR_FIRST: if (load_w & half_s) nxt_pair = PAIR_SECOND;
      PAIR_SECOND: if (load_w | ~half_s) nxt_pair = PAIR_FIRST;
    endcase
  end

  // word phase, pairing, lane words, link clock
  always_ff @(posedge pixel_clock_input or posedge link_rst_ff) begin
    if (link_rst_ff) begin
      phase_ff <= '0;
      pair_ff <= PAIR_FIRST;
      lane_word_ff <= '0;
      pri_clk_ff <= 1'b0;
      div_ff <= '0;
    end else begin
      phase_ff <= load_w ? '0 : phase_ff + 1'b1;
      pair_ff <= nxt_pair;
      lane_word_ff <= nxt_word;
      pri_clk_ff <= LINK_CLK_PATTERN[phase_ff];
      div_ff <= div_ff + 1'b1;
    end
  end

  // hold first pixel of a pair
  always_ff @(posedge pixel_clock_input or posedge link_rst_ff) begin
    if (link_rst_ff) begin
      first_pix_ff <= '0;
      first_act_ff <= 1'b0;
    end else if (load_w & (pair_ff == PAIR_FIRST)) begin
      first_pix_ff <= pix_lo;
      first_act_ff <= active_w;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // lane serializers and output pins

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    lane_if #(.W(WORD_BITS)) lane_bus ();
    assign lane_bus.word = lane_word_ff[i];
    assign lane_bus.load = load_w;
    assign lane_bit[i] = lane_bus.bit_out;
    lane_serializer #(.W(WORD_BITS)) u_ser (
      .clk(pixel_clock_input),
      .rst(link_rst_ff),
      .lane(lane_bus)
    );
  end

  assign serial_lane_oe = {{4{awake_s & ~single_s}}, {4{awake_s}}};
  assign primary_link_clock_oe = awake_s;
  assign secondary_link_clock_oe = awake_s & ~single_s;
  assign serial_lane_pos = lane_bit;
  assign serial_lane_neg = ~lane_bit;
  assign primary_link_clock_pos = pri_clk_ff;
  assign primary_link_clock_neg = ~pri_clk_ff;
  assign secondary_link_clock_pos = pri_clk_ff;
  assign secondary_link_clock_neg = ~pri_clk_ff;

  //////////////////////////////////////////////////////////////////////
  // assertions

  a_sleep_tristate: assert property (
    @(posedge pixel_clock_input) disable iff (link_rst_ff)
    !awake_s |-> (serial_lane_oe == '0) && !primary_link_clock_oe
                 && !secondary_link_clock_oe)
    else $error("outputs driven while asleep");

  a_single_lanes: assert property (
    @(posedge pixel_clock_input) disable iff (link_rst_ff)
    awake_s && mode_s == WIDTH_SINGLE |->
      serial_lane_oe == 8'h0f && !secondary_link_clock_oe
      && primary_link_clock_oe)
    else $error("single mode lane enables wrong");

  a_dual_lanes: assert property (
    @(posedge pixel_clock_input) disable iff (link_rst_ff)
    awake_s && mode_s == WIDTH_DUAL |-> serial_lane_oe == 8'hff)
    else $error("dual mode lanes not all enabled");

  a_second_clock: assert property (
    @(posedge pixel_clock_input) disable iff (link_rst_ff)
    secondary_link_clock_pos == primary_link_clock_pos &&
    secondary_link_clock_neg == primary_link_clock_neg)
    else $error("secondary clock differs");

  a_rise_capture: assert property (
    @(posedge pixel_clock_input) disable iff (link_rst_ff)
    edge_s && $past(edge_s) && $past(edge_s, 2) |->
      pix_ff == $past(in_vec, 2))
    else $error("rising edge capture lost");

  a_enable_polarity: assert property (
    @(posedge pixel_clock_input) disable iff (link_rst_ff)
    active_w == (pol_s ? pix_ff[IN_W-1] : !pix_ff[IN_W-1]))
    else $error("data enable polarity wrong");

  a_balanced_word: assert property (
    @(posedge pixel_clock_input) disable iff (link_rst_ff)
    upd_words && bal_s |=> $countones(lane_word_ff[0][5:0]) <= 3)
    else $error("balanced word has excess ones");

  a_plain_ctrl: assert property (
    @(posedge pixel_clock_input) disable iff (link_rst_ff)
    upd_words && !bal_s && !half_s |=>
      lane_word_ff[0][6] == $past(pix_ff[IN_W-3]))
    else $error("plain word lost hsync");

  a_word_period: assert property (
    @(posedge pixel_clock_input) disable iff (link_rst_ff)
    load_w |=> !load_w [*6] ##1 load_w)
    else $error("word period not seven");

  a_range_manual: assert property (
    @(posedge sys_clk) disable iff (rst)
    !range_auto && $past(!range_auto) |-> !high_range_ff)
    else $error("range switched without auto");

  c_single_load: cover property (@(posedge pixel_clock_input)
    disable iff (link_rst_ff) upd_words && single_s && awake_s);
  c_dual_load: cover property (@(posedge pixel_clock_input)
    disable iff (link_rst_ff) upd_words && mode_s == WIDTH_DUAL);
  c_half_pair: cover property (@(posedge pixel_clock_input)
    disable iff (link_rst_ff) half_s && pair_ff == PAIR_SECOND && load_w);
  c_high_range: cover property (@(posedge sys_clk)
    disable iff (rst) $rose(high_range_ff));
endmodule : disp_tx

// ===== sim/lane_rx_model.sv
// receiver side model: gathers serial lane and link clock bit windows
module lane_rx_model (
  // link clock
  input wire logic pclk,
  // serial lanes and link clock from the transmitter
  input wire logic [disp_tx_pkg::LANES-1:0] lane_pos,
  input wire logic clk_pos,
  // last seven bits of each line, lsb first
  output logic [disp_tx_pkg::LANES-1:0][6:0] win,
  output logic [6:0] clk_win
);
  timeunit 1ns;
  timeprecision 1ps;
  import disp_tx_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // deserialize every lane
  // sampled mid-bit, away from the launching edge, to dodge races
  always @(negedge pclk) begin
    for (int k = 0; k < LANES; k++) begin
      win[k] <= {lane_pos[k], win[k][6:1]};
    end
    clk_win <= {clk_pos, clk_win[6:1]};
  end
endmodule : lane_rx_model

// ===== sim/disp_tx_test.sv
// self-checking bench of the display transmitter with a receiver model
module disp_tx_test;
  timeunit 1ns;
  timeprecision 1ps;
  import disp_tx_pkg::*;

  logic sys_clk, rst, pclk;
  logic psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  logic [15:0] red_in, green_in, blue_in;
  logic hsync_in, vsync_in, data_enable_in;
  logic [7:0] lane_pos, lane_neg, lane_oe;
  logic p_pos, p_neg, p_oe, s_pos, s_neg, s_oe;
  logic [7:0][6:0] win;
  logic [6:0] clk_win;
  logic [47:0] px_p, px_q;
  logic [31:0] q;
  logic err, mon;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 6161;

  ////////////////////////////////////////////////////////////////////////
  // clocks: system 8 ns, link 15 ns with its own phase
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    pclk = 1'b0;
    #3;
    forever #7.5 pclk = ~pclk;
  end

  disp_tx disp_tx_inst (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pixel_clock_input(pclk),
    .red_in(red_in), .green_in(green_in), .blue_in(blue_in),
    .hsync_in(hsync_in), .vsync_in(vsync_in),
    .data_enable_in(data_enable_in), .serial_lane_pos(lane_pos),
    .serial_lane_neg(lane_neg), .serial_lane_oe(lane_oe),
    .primary_link_clock_pos(p_pos), .primary_link_clock_neg(p_neg),
    .primary_link_clock_oe(p_oe), .secondary_link_clock_pos(s_pos),
    .secondary_link_clock_neg(s_neg), .secondary_link_clock_oe(s_oe)
  );
  lane_rx_model lane_rx_model_inst (
    .pclk(pclk), .lane_pos(lane_pos), .clk_pos(p_pos), .win(win),
    .clk_win(clk_win)
  );

  ////////////////////////////////////////////////////////////////////////
  // pixel drive: one value seen by rising edges, another by falling
  always @(posedge pclk) begin
    {red_in, green_in, blue_in} <= px_q;
  end
  always @(negedge pclk) begin
    {red_in, green_in, blue_in} <= px_p;
  end

  // line level checks while the link is running
  always @(negedge pclk) begin
    if (mon) begin
      chk("lane_neg", {24'h0, ~lane_pos}, {24'h0, lane_neg});
      chk("sec_clk", {31'h0, p_pos}, {31'h0, s_pos});
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare tasks and the expected lane word
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_rot(input string nm, input logic [6:0] e,
                         input logic [6:0] g);
    logic [13:0] d;
    bit hit;
    d = {e, e};
    hit = 0;
    for (int r = 0; r < 7; r++) begin
      if (d[r +: 7] === g) begin
        hit = 1;
      end
    end
    comparisons++;
    if (!hit) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_rot

  function automatic logic [6:0] exp_word(int k, logic [23:0] a,
      logic [2:0] ctl, bit act, bit dc_equalized_coding_select);
    logic [5:0] d;
    logic c;
    d = a[6*k +: 6];
    c = (k == 3) ? 1'b0 : ctl[k];
    if (dc_equalized_coding_select && !act) begin
      return {1'b0, c ? BLANK_HI : BLANK_LO};
    end
    // balanced data: invert and flag when more than half are ones
    if (dc_equalized_coding_select) begin
      return ($countones(d) > 3) ? {1'b1, ~d} : {1'b0, d};
    end
    return {c, act ? d : 6'h00};
  endfunction : exp_word

  ////////////////////////////////////////////////////////////////////////
  // apb master: setup, access until pready, release
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  // one link configuration, checked at the lanes and in status
  task automatic run_cfg(input logic [1:0] mode, input bit dc_equalized_coding_select,
                         input bit edge_sel, input bit pol);
    logic [63:0] rnd;
    logic [31:0] cv;
    logic [2:0] ctl;
    logic [47:0] px;
    logic [23:0] lo, hi;
    logic [6:0] e;
    bit act, single;
    rnd = {$random(seed), $random(seed)};
    px_p = rnd[47:0];
    rnd = {$random(seed), $random(seed)};
    px_q = rnd[47:0];
    ctl = 3'($random(seed));
    single = (mode == 2'b00) || (mode == 2'b11);
    // balanced runs: active pixels in dual mode, blanking otherwise
    if (dc_equalized_coding_select) begin
      ctl[2] = (mode == 2'b01) ? pol : ~pol;
    end
    act = pol ? ctl[2] : ~ctl[2];
    px = edge_sel ? px_p : px_q;
    lo = {px[39:32], px[23:16], px[7:0]};
    hi = {px[47:40], px[31:24], px[15:8]};
    {data_enable_in, vsync_in, hsync_in} <= ctl;
    // wake and auto range always on
    cv = {25'h0, 2'b11, mode, dc_equalized_coding_select, pol, edge_sel};
    apb(1'b1, CTRL_OFS, cv);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl_rd", cv, q);
    repeat (40) @(posedge pclk);
    mon = 1'b1;
    repeat (10) @(negedge pclk);
    #1;
    chk("lane_oe", single ? 32'h0f : 32'hff, {24'h0, lane_oe});
    chk("clk_oe", {30'h0, 1'b1, !single}, {30'h0, p_oe, s_oe});
    chk_rot("link_clk", LINK_CLK_PATTERN, clk_win);
    for (int k = 0; k < 4; k++) begin
      e = exp_word(k, lo, ctl, act, dc_equalized_coding_select);
      chk_rot("lane_word", e, win[k]);
      e = exp_word(k, mode == 2'b10 ? lo : hi, ctl, act, dc_equalized_coding_select);
      chk_rot("lane_hi", single ? 7'h00 : e, win[k+4]);
    end
    mon = 1'b0;
    repeat (1300) @(posedge sys_clk);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", 32'h3, {30'h0, q[1:0]});
    $display("cfg mode %0d bal %0d done", mode, dc_equalized_coding_select);
  endtask : run_cfg

  task automatic finish_test;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the expected run of about 90 us
  initial begin
    #500000;
    num_errors++;
    finish_test();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, mon} = '0;
    {hsync_in, vsync_in, data_enable_in} = '0;
    {px_p, px_q, red_in, green_in, blue_in} = '0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl_rst", {25'h0, CTRL_RESET}, q);
    chk("oe_sleep", 32'h0, {22'h0, lane_oe, p_oe, s_oe});
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmap_rd", 32'h0, q);
    apb(1'b1, STATUS_OFS, 32'hffffffff);
    apb(1'b1, 8'h0c, 32'hffffffff);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl_keep", 32'h0, q);
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      run_cfg(2'(i % 4), 1'(i / 4), 1'($random(seed)), 1'($random(seed)));
    end
    apb(1'b1, CTRL_OFS, 32'h0);
    repeat (20) @(posedge pclk);
    chk("oe_off", 32'h0, {22'h0, lane_oe, p_oe, s_oe});
    @(posedge sys_clk);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status_off", 32'h0, {30'h0, q[1:0]});
    $display("sleep test done");
    finish_test();
  end
endmodule : disp_tx_test
